// ===== bcd_logic_rotate_alu.sv
// byte-wide decimal adjust, logic, compare and rotate datapath with axi4-lite registers
`timescale 1ns/1ps
module bcd_logic_rotate_alu (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // memory operand path
    output logic             mem_req_o,
    output logic [15:0]      mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [7:0]  mem_rdata_i,
    // sequencer view
    output logic             busy_o
);

    // reset image of the whole state; ready lines start high so no edge is wasted
    localparam bcd_logic_rotate_alu_pkg::state_s RESET_STATE = '{
        regs:      '0,
        flags:     '0,
        immediate: bcd_logic_rotate_alu_pkg::RESET_BYTE,
        phase:     bcd_logic_rotate_alu_pkg::PHASE_IDLE,
        op:        bcd_logic_rotate_alu_pkg::OP_DECIMAL_ADJUST,
        operand:   bcd_logic_rotate_alu_pkg::RESET_BYTE,
        need_mem:  1'b0,
        count:     5'h00,
        done:      1'b0,
        mem_req:   1'b0,
        mem_addr:  16'h0000,
        aw_full:   1'b0,
        aw_addr:   8'h00,
        w_full:    1'b0,
        w_data:    32'h0000_0000,
        w_lane0:   1'b0,
        aw_rdy:    1'b1,
        w_rdy:     1'b1,
        bvalid:    1'b0,
        bresp:     bcd_logic_rotate_alu_pkg::RESP_OKAY,
        ar_rdy:    1'b1,
        rvalid:    1'b0,
        rdata:     32'h0000_0000,
        rresp:     bcd_logic_rotate_alu_pkg::RESP_OKAY
    };

    bcd_logic_rotate_alu_pkg::state_s st;      // registered state
    bcd_logic_rotate_alu_pkg::state_s next_st; // value for the next edge

    // pack the flags into the software-visible byte
    function automatic logic [7:0] flags_to_byte(input bcd_logic_rotate_alu_pkg::flags_s f);
        logic [7:0] b;
        b = 8'h00;
        b[bcd_logic_rotate_alu_pkg::FLAG_CARRY_BIT]  = f.carry;
        b[bcd_logic_rotate_alu_pkg::FLAG_PARITY_BIT] = f.parity;
        b[bcd_logic_rotate_alu_pkg::FLAG_HALF_BIT]   = f.half;
        b[bcd_logic_rotate_alu_pkg::FLAG_ZERO_BIT]   = f.zero;
        b[bcd_logic_rotate_alu_pkg::FLAG_SIGN_BIT]   = f.sign;
        return b;
    endfunction

    // unpack a written byte into flags
    function automatic bcd_logic_rotate_alu_pkg::flags_s byte_to_flags(input logic [7:0] b);
        bcd_logic_rotate_alu_pkg::flags_s f;
        f.carry  = b[bcd_logic_rotate_alu_pkg::FLAG_CARRY_BIT];
        f.parity = b[bcd_logic_rotate_alu_pkg::FLAG_PARITY_BIT];
        f.half   = b[bcd_logic_rotate_alu_pkg::FLAG_HALF_BIT];
        f.zero   = b[bcd_logic_rotate_alu_pkg::FLAG_ZERO_BIT];
        f.sign   = b[bcd_logic_rotate_alu_pkg::FLAG_SIGN_BIT];
        return f;
    endfunction

    // zero, sign and parity from a result byte; the carries are left to the caller
    function automatic bcd_logic_rotate_alu_pkg::flags_s result_flags(
        input logic [7:0]                       r,
        input bcd_logic_rotate_alu_pkg::flags_s old
    );
        bcd_logic_rotate_alu_pkg::flags_s f;
        f        = old;
        f.zero   = (r == 8'h00);
        f.sign   = r[7];
        f.parity = ~^r;          // even count of ones
        return f;
    endfunction

    // number of cycles an operation occupies, from its state count
    function automatic logic [4:0] op_cycles(input logic [3:0] op, input logic from_mem);
        int s;
        s = bcd_logic_rotate_alu_pkg::STATES_SHORT;
        case (op)
            bcd_logic_rotate_alu_pkg::OP_DECIMAL_ADJUST: s = bcd_logic_rotate_alu_pkg::STATES_DAA;
            bcd_logic_rotate_alu_pkg::OP_XOR_IMMEDIATE,
            bcd_logic_rotate_alu_pkg::OP_OR_IMMEDIATE: s = bcd_logic_rotate_alu_pkg::STATES_IMM;
            bcd_logic_rotate_alu_pkg::OP_XOR_REG_MEM,
            bcd_logic_rotate_alu_pkg::OP_OR_REG_MEM,
            bcd_logic_rotate_alu_pkg::OP_COMPARE_REG_MEM: begin
                // memory forms take the longer count register form short
                s = from_mem ? bcd_logic_rotate_alu_pkg::STATES_MEM
                             : bcd_logic_rotate_alu_pkg::STATES_REG;
            end
            default: s = bcd_logic_rotate_alu_pkg::STATES_SHORT; // rotates and carry ops
        endcase
        return 5'(s * bcd_logic_rotate_alu_pkg::CYCLES_PER_STATE);
    endfunction

    // true for every code the sequencer accepts
    function automatic logic op_known(input logic [3:0] op);
        return op <= bcd_logic_rotate_alu_pkg::OP_FORCE_CARRY;
    endfunction

    // the datapath proper: result byte, whether it is written, and new flags
    function automatic logic [16:0] execute(
        input logic [3:0]                       op,
        input logic [7:0]                       a,
        input logic [7:0]                       b,
        input bcd_logic_rotate_alu_pkg::flags_s f
    );
        logic [7:0]  r;
        logic        wr;
        logic        lo_fix;
        logic        hi_fix;
        logic [4:0]  lo_sum;
        logic [8:0]  t1;
        logic [8:0]  t2;
        logic [8:0]  diff;
        bcd_logic_rotate_alu_pkg::flags_s nf;
        r      = a;
        wr     = 1'b0;
        nf     = f;
        lo_fix = 1'b0;
        hi_fix = 1'b0;
        lo_sum = 5'h00;
        t1     = 9'h000;
        t2     = 9'h000;
        diff   = 9'h000;
        case (op)
            bcd_logic_rotate_alu_pkg::OP_DECIMAL_ADJUST: begin
                lo_fix = (a[3:0] > 4'h9) | f.half;
                lo_sum = {1'b0, a[3:0]} + 5'h06;
                t1     = {1'b0, a} + (lo_fix ? 9'h006 : 9'h000);
                hi_fix = (t1[7:4] > 4'h9) | f.carry | t1[8];
                t2     = t1 + (hi_fix ? 9'h060 : 9'h000);
                r      = t2[7:0];
                wr     = 1'b1;
                nf     = result_flags(r, f);
                nf.half  = lo_fix & lo_sum[4];
                nf.carry = hi_fix;
            end
            bcd_logic_rotate_alu_pkg::OP_XOR_REG_MEM,
            bcd_logic_rotate_alu_pkg::OP_XOR_IMMEDIATE: begin
                r  = a ^ b;
                wr = 1'b1;
                nf = result_flags(r, f);
                nf.carry = 1'b0;
                nf.half  = 1'b0;
            end
            bcd_logic_rotate_alu_pkg::OP_OR_REG_MEM,
            bcd_logic_rotate_alu_pkg::OP_OR_IMMEDIATE: begin
                r  = a | b;
                wr = 1'b1;
                nf = result_flags(r, f);
                nf.carry = 1'b0;
                nf.half  = 1'b0;
            end
            bcd_logic_rotate_alu_pkg::OP_COMPARE_REG_MEM: begin
                // flags from a minus b, accumulator never written
                diff = {1'b0, a} - {1'b0, b};
                nf = result_flags(diff[7:0], f);
                nf.carry = diff[8];                // borrow
                nf.half  = (a[3:0] >= b[3:0]);     // no borrow from low nibble
            end
            bcd_logic_rotate_alu_pkg::OP_ROTATE_LEFT: begin
                r  = {a[6:0], a[7]};
                wr = 1'b1;
                nf.carry = a[7];     // only carry moves
            end
            bcd_logic_rotate_alu_pkg::OP_ROTATE_RIGHT: begin
                r  = {a[0], a[7:1]};
                wr = 1'b1;
                nf.carry = a[0];
            end
            bcd_logic_rotate_alu_pkg::OP_INVERT_CARRY: nf.carry = ~f.carry;
            bcd_logic_rotate_alu_pkg::OP_FORCE_CARRY:  nf.carry = 1'b1;
            default: nf = f; // unknown codes never reach here
        endcase
        return {r, wr, flags_to_byte(nf)};
    endfunction

    // read mux over the register map; unmapped answers zero with slverr
    function automatic logic [33:0] read_word(
        input bcd_logic_rotate_alu_pkg::state_s s,
        input logic [7:0]                       addr
    );
        logic [31:0] d;
        logic [1:0]  resp;
        d    = 32'h0000_0000;
        resp = bcd_logic_rotate_alu_pkg::RESP_OKAY;
        if (addr == bcd_logic_rotate_alu_pkg::ADDR_ACCUMULATOR) begin
            d[7:0] = s.regs[bcd_logic_rotate_alu_pkg::SRC_ACCUM];
        end else if (addr == bcd_logic_rotate_alu_pkg::ADDR_FLAGS) begin
            d[7:0] = flags_to_byte(s.flags);
        end else if (addr == bcd_logic_rotate_alu_pkg::ADDR_IMMEDIATE) begin
            d[7:0] = s.immediate;
        end else if (addr == bcd_logic_rotate_alu_pkg::ADDR_COMMAND) begin
            d[7:0] = {1'b0, 3'h0, s.op};
        end else if (addr == bcd_logic_rotate_alu_pkg::ADDR_STATUS) begin
            d[bcd_logic_rotate_alu_pkg::STATUS_BUSY_BIT] =
                (s.phase == bcd_logic_rotate_alu_pkg::PHASE_RUN);
            d[bcd_logic_rotate_alu_pkg::STATUS_DONE_BIT] = s.done;
        end else if (addr >= bcd_logic_rotate_alu_pkg::ADDR_REGFILE &&
                     addr <= bcd_logic_rotate_alu_pkg::ADDR_REGFILE_END &&
                     addr[1:0] == 2'h0) begin
            // slot 6 stands for memory and reads zero
            if (addr[4:2] != bcd_logic_rotate_alu_pkg::SRC_MEMORY) begin
                d[7:0] = s.regs[addr[4:2]];
            end
        end else begin
            resp = bcd_logic_rotate_alu_pkg::RESP_SLVERR;
        end
        return {resp, d};
    endfunction

    // next-state logic: bus slave, register writes and the operation sequencer
    always_comb begin
        logic [33:0] rd;
        logic [16:0] ex;
        logic        busy;
        logic        finish;
        logic        wr_ok;
        logic [2:0]  src;
        rd      = 34'h0_0000_0000;
        ex      = 17'h0_0000;
        next_st = st;
        busy    = (st.phase == bcd_logic_rotate_alu_pkg::PHASE_RUN);
        finish  = 1'b0;
        wr_ok   = 1'b0;
        src     = st.w_data[bcd_logic_rotate_alu_pkg::CMD_SRC_LSB +: 3];

        // sequencer: count down, take memory byte, retire the operation
        if (busy) begin
            if (st.count != 5'h00) begin
                next_st.count = st.count - 5'h01;
            end
            if (st.need_mem && mem_ack_i) begin
                next_st.operand  = mem_rdata_i; // byte at the pointer pair
                next_st.need_mem = 1'b0;
                next_st.mem_req  = 1'b0;
            end
            // a slow memory stretches the operation past its nominal count
            finish = (st.count <= 5'h01) && !st.need_mem;
            if (finish) begin
                ex = execute(st.op, st.regs[bcd_logic_rotate_alu_pkg::SRC_ACCUM],
                             st.operand, st.flags);
                if (ex[8]) begin
                    next_st.regs[bcd_logic_rotate_alu_pkg::SRC_ACCUM] = ex[16:9];
                end
                next_st.flags = byte_to_flags(ex[7:0]);
                next_st.phase = bcd_logic_rotate_alu_pkg::PHASE_IDLE;
                next_st.done  = 1'b1;
            end
        end

        // write address and data are taken independently, in either order
        if (s_axi_awvalid_i && st.aw_rdy) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = s_axi_awaddr_i;
            next_st.aw_rdy  = 1'b0;
        end
        if (s_axi_wvalid_i && st.w_rdy) begin
            next_st.w_full  = 1'b1;
            next_st.w_data  = s_axi_wdata_i;
            next_st.w_lane0 = s_axi_wstrb_i[0];
            next_st.w_rdy   = 1'b0;
        end

        // both halves held: perform the write and raise the response
        if (st.aw_full && st.w_full && !st.bvalid) begin
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            rd = read_word(st, st.aw_addr);
            next_st.bresp = rd[33:32];
            wr_ok = st.w_lane0 && (rd[33:32] == bcd_logic_rotate_alu_pkg::RESP_OKAY);
            // registers the sequencer uses are frozen while an operation runs
            if (wr_ok && !busy) begin
                if (st.aw_addr == bcd_logic_rotate_alu_pkg::ADDR_ACCUMULATOR) begin
                    next_st.regs[bcd_logic_rotate_alu_pkg::SRC_ACCUM] = st.w_data[7:0];
                end else if (st.aw_addr == bcd_logic_rotate_alu_pkg::ADDR_FLAGS) begin
                    next_st.flags = byte_to_flags(st.w_data[7:0]);
                end else if (st.aw_addr == bcd_logic_rotate_alu_pkg::ADDR_IMMEDIATE) begin
                    next_st.immediate = st.w_data[7:0];
                end else if (st.aw_addr >= bcd_logic_rotate_alu_pkg::ADDR_REGFILE &&
                             st.aw_addr[4:2] != bcd_logic_rotate_alu_pkg::SRC_MEMORY) begin
                    next_st.regs[st.aw_addr[4:2]] = st.w_data[7:0];
                end else if (st.aw_addr == bcd_logic_rotate_alu_pkg::ADDR_COMMAND &&
                             op_known(st.w_data[3:0])) begin
                    // launch: capture the operand, or the fetch address for memory forms, now so a later write cannot disturb it
                    next_st.op    = st.w_data[bcd_logic_rotate_alu_pkg::CMD_OP_LSB +: 4];
                    next_st.phase = bcd_logic_rotate_alu_pkg::PHASE_RUN;
                    next_st.count = op_cycles(next_st.op, src == bcd_logic_rotate_alu_pkg::SRC_MEMORY);
                    if (next_st.op == bcd_logic_rotate_alu_pkg::OP_XOR_IMMEDIATE ||
                        next_st.op == bcd_logic_rotate_alu_pkg::OP_OR_IMMEDIATE) begin
                        next_st.operand = st.immediate; // second instruction byte
                    end else if (src == bcd_logic_rotate_alu_pkg::SRC_MEMORY &&
                                 (next_st.op == bcd_logic_rotate_alu_pkg::OP_XOR_REG_MEM ||
                                  next_st.op == bcd_logic_rotate_alu_pkg::OP_OR_REG_MEM ||
                                  next_st.op == bcd_logic_rotate_alu_pkg::OP_COMPARE_REG_MEM)) begin
                        // fetch through the high/low pointer pair
                        next_st.need_mem = 1'b1;
                        next_st.mem_req  = 1'b1;
                        next_st.mem_addr = {st.regs[bcd_logic_rotate_alu_pkg::SRC_HIGH_PTR],
                                            st.regs[bcd_logic_rotate_alu_pkg::SRC_LOW_PTR]};
                    end else begin
                        next_st.operand = st.regs[src]; // source register field
                    end
                end
            end
            // done is cleared by writing one; a retire in the same cycle wins
            if (wr_ok && st.aw_addr == bcd_logic_rotate_alu_pkg::ADDR_STATUS &&
                st.w_data[bcd_logic_rotate_alu_pkg::STATUS_DONE_BIT] && !finish) begin
                next_st.done = 1'b0;
            end
        end

        // response accepted: reopen both write channels
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
            next_st.aw_rdy = 1'b1;
            next_st.w_rdy  = 1'b1;
        end

        // read channel: one read under way, data one edge after the address
        if (s_axi_arvalid_i && st.ar_rdy) begin
            rd = read_word(st, s_axi_araddr_i);
            next_st.rdata  = rd[31:0];
            next_st.rresp  = rd[33:32];
            next_st.rvalid = 1'b1;
            next_st.ar_rdy = 1'b0;
        end
        if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
            next_st.ar_rdy = 1'b1;
        end
    end

    // single state register; clock enable low freezes everything
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st <= RESET_STATE;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready_o = st.aw_rdy;
    assign s_axi_wready_o  = st.w_rdy;
    assign s_axi_bvalid_o  = st.bvalid;
    assign s_axi_bresp_o   = st.bresp;
    assign s_axi_arready_o = st.ar_rdy;
    assign s_axi_rvalid_o  = st.rvalid;
    assign s_axi_rdata_o   = st.rdata;
    assign s_axi_rresp_o   = st.rresp;
    assign mem_req_o       = st.mem_req;
    assign mem_addr_o      = st.mem_addr;
    assign busy_o          = (st.phase == bcd_logic_rotate_alu_pkg::PHASE_RUN);

endmodule

// ===== bcd_logic_rotate_alu_bench.sv
// random bench of the alu slice, operations checked through the register bus
`timescale 1ns/1ps
module bcd_logic_rotate_alu_bench;
    logic        clk_i = 0, reset_i = 1, av = 0, wv = 0, br = 0, arv = 0, rr = 0, pb = 0, m;
    logic        awr, wrd, bv, arr, rv, req, ack, busy, ce = 1;
    logic [1:0]  rs, bs, r;
    logic [2:0]  lag = 3'h0, src;
    logic [3:0]  ws = 4'h1, op;
    logic [7:0]  aa = 8'h00, ra = 8'h00, md, a, f, rg [8];
    logic [15:0] maddr;
    logic [31:0] wd = 32'h0000_0000, rdo, d, seed = 32'h0001_6110;
    int          failures = 0, n_tests = 0, bc = 0, cyc = 0, st, hold;
    bcd_logic_rotate_alu dut_u (.clk_i, .reset_i, .ce_i(ce), .s_axi_awaddr_i(aa),
        .s_axi_awvalid_i(av), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(bs), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(br), .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdo), .s_axi_rresp_o(rs), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .mem_req_o(req), .mem_addr_o(maddr), .mem_ack_i(ack), .mem_rdata_i(md), .busy_o(busy));
    mem_model mem_u (.clk_i, .req_i(req), .lag_i(lag), .addr_i(maddr), .ack_o(ack), .data_o(md));
    initial forever #50 clk_i = ~clk_i;
    // length of the last busy run, and a hang guard
    always @(posedge clk_i) begin
        pb <= busy;
        bc <= busy ? (pb ? bc + 1 : 1) : bc;
        cyc <= cyc + 1;
        if (cyc == 40000) begin failures++; conclude(); end
    end
    task automatic chk(input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one transfer; each valid is held until its own ready, read data lands in d and the response in r
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk_i);
        {aa, ra, wd, ws, av, wv, br, arv, rr} <= {ad, ad, dt, 4'(rnd()) | 4'h1, w, w, w, !w, !w};
        do begin
            @(posedge clk_i);
            if (awr) av <= 0;
            if (wrd) wv <= 0;
            if (arr) arv <= 0;
        end while (!(w ? bv : rv));
        d = rdo;
        r = w ? bs : rs;
        {br, rr} <= 2'b00;
    endtask
    // expected {accumulator, flags}
    function automatic logic [15:0] ex(logic [3:0] o, logic [7:0] x, y, f);
        logic [8:0] t;
        logic [7:0] v;
        logic       c, h;
        t = x + ((x[3:0] > 9 || f[4]) ? 9'h006 : 9'h000);
        c = t[7:4] > 9 || f[0] || t[8];
        h = x[3:0] > 9;
        v = t[7:0] + (c ? 8'h60 : 8'h00);
        if (o > 5) return o > 7 ? {x, f[7:1], o[0] | ~f[0]} : o[0] ?
            {x[0], x[7:1], f[7:1], x[0]} : {x[6:0], x[7], f[7:1], x[7]};
        if (o > 0) {c, h, v} = {2'b00, o < 3 ? x ^ y : x | y};
        if (o == 5) {c, h, v} = {x < y, x[3:0] >= y[3:0], x - y};
        return {o == 5 ? x : v, v[7], v == 8'h00, 1'b0, h, 1'b0, ~^v, 1'b0, c};
    endfunction
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 0;
        bus(0, 8'h04, 0);
        chk({d[13:0], r}, 16'h0000);
        bus(0, 8'h14, 0);
        chk({d[13:0], r}, 16'h0002);
        for (int i = 0; i < 80; i++) begin
            op = i < 10 ? 4'(i) : 4'(rnd() % 10);
            src = 3'(rnd());
            m = src == 6 && op inside {1, 3, 5};
            f = 8'(rnd()) & 8'hd5;
            lag <= 3'(rnd());
            for (int k = 0; k < 8; k++) begin
                rg[k] = 8'(rnd());
                bus(1, 8'h20 + 8'(4 * k), 32'(rg[k]));
            end
            bus(1, 8'h08, 32'(rg[6]));
            bus(1, 8'h04, 32'(f));
            // clear done first so the status check below proves this op set it
            bus(1, 8'h10, 32'h0000_0002);
            chk(16'(r), 16'h0000);
            bus(0, 8'h10, 0);
            chk(16'(d[1:0]), 16'h0000);
            bus(1, 8'h0c, 32'({src, op}));
            // a clock-enable stall mid-op must stretch busy by exactly its length
            hold = (i % 16 == 9 && !m) ? 5 : 0;
            if (hold > 0) begin
                ce <= 0;
                repeat (hold) @(posedge clk_i);
                ce <= 1;
            end
            do bus(0, 8'h10, 0); while (d[0] !== 1'b0);
            chk(16'(d[1:0]), 16'h0002);
            st = op == 0 ? 10 : (m || op inside {2, 4}) ? 7 : 4;
            if (!m || lag < 3) chk(16'(bc), 16'(st + hold));
            bus(0, 8'h00, 0);
            a = d[7:0];
            bus(0, 8'h04, 0);
            chk({a, d[7:0]}, ex(op, rg[7], op inside {2, 4} ? rg[6] : src == 6 ?
                rg[4] ^ rg[5] ^ 8'h5a : rg[src], f));
        end
        conclude();
    end
endmodule

// ===== bcd_logic_rotate_alu_pkg.sv
// constants, encodings and state carriers of the byte-wide alu slice
package bcd_logic_rotate_alu_pkg;

    // register byte addresses on the axi4-lite bus
    localparam logic [7:0] ADDR_ACCUMULATOR = 8'h00;
    localparam logic [7:0] ADDR_FLAGS       = 8'h04;
    localparam logic [7:0] ADDR_IMMEDIATE   = 8'h08;
    localparam logic [7:0] ADDR_COMMAND     = 8'h0C;
    localparam logic [7:0] ADDR_STATUS      = 8'h10;
    localparam logic [7:0] ADDR_REGFILE     = 8'h20; // eight words, source field order
    localparam logic [7:0] ADDR_REGFILE_END = 8'h3C;

    // register file slots addressed by the three-bit source field
    localparam logic [2:0] SRC_HIGH_PTR   = 3'h4;
    localparam logic [2:0] SRC_LOW_PTR    = 3'h5;
    localparam logic [2:0] SRC_MEMORY     = 3'h6;
    localparam logic [2:0] SRC_ACCUM      = 3'h7;

    // flag byte bit positions
    localparam int FLAG_CARRY_BIT  = 0;
    localparam int FLAG_PARITY_BIT = 2;
    localparam int FLAG_HALF_BIT   = 4;
    localparam int FLAG_ZERO_BIT   = 6;
    localparam int FLAG_SIGN_BIT   = 7;

    // command word fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_SRC_LSB = 4;

    // status word bits
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;

    // operation codes written into the command field
    localparam logic [3:0] OP_DECIMAL_ADJUST = 4'h0;
    localparam logic [3:0] OP_XOR_REG_MEM    = 4'h1;
    localparam logic [3:0] OP_XOR_IMMEDIATE  = 4'h2;
    localparam logic [3:0] OP_OR_REG_MEM     = 4'h3;
    localparam logic [3:0] OP_OR_IMMEDIATE   = 4'h4;
    localparam logic [3:0] OP_COMPARE_REG_MEM = 4'h5;
    localparam logic [3:0] OP_ROTATE_LEFT    = 4'h6;
    localparam logic [3:0] OP_ROTATE_RIGHT   = 4'h7;
    localparam logic [3:0] OP_INVERT_CARRY   = 4'h8;
    localparam logic [3:0] OP_FORCE_CARRY    = 4'h9;

    // timing: one state lasts one processor clock period
    localparam int CLK_PERIOD_NS    = 100;
    localparam int STATE_NS         = 100;
    localparam int CYCLES_PER_STATE = (STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATES_REG   = 4;
    localparam int STATES_MEM   = 7;
    localparam int STATES_IMM   = 7;
    localparam int STATES_DAA   = 10;
    localparam int STATES_SHORT = 4;

    // axi response codes and reset values
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] RESET_BYTE  = 8'h00;

    // sequencer phases
    typedef enum logic {PHASE_IDLE, PHASE_RUN} phase_e;

    // condition flags as one carrier
    typedef struct packed {
        logic sign;
        logic zero;
        logic half;
        logic parity;
        logic carry;
    } flags_s;

    // whole state of the block
    typedef struct packed {
        logic [7:0][7:0] regs;      // slot 7 is the accumulator, slot 6 unused
        flags_s          flags;
        logic [7:0]      immediate;
        phase_e          phase;
        logic [3:0]      op;
        logic [7:0]      operand;
        logic            need_mem;  // operand still awaited from memory
        logic [4:0]      count;     // remaining cycles of the operation
        logic            done;
        logic            mem_req;
        logic [15:0]     mem_addr;
        logic            aw_full;
        logic [7:0]      aw_addr;
        logic            w_full;
        logic [31:0]     w_data;
        logic            w_lane0;
        logic            aw_rdy;
        logic            w_rdy;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            ar_rdy;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } state_s;

endpackage

// ===== bcd_logic_rotate_alu_sva.sv
// port checker of the alu slice
`timescale 1ns/1ps
module bcd_logic_rotate_alu_sva (
    input wire logic        clk_i, reset_i, ce_i, busy_o, mem_req_o, mem_ack_i,
    input wire logic        s_axi_rvalid_o, s_axi_rready_i, s_axi_arready_o,
    input wire logic [15:0] mem_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_run4; busy_o [*4]; endsequence
    property p_run; $rose(busy_o) |-> s_run4; endproperty
    a_run: assert property (p_run) else $error("short op");
    property p_req; mem_req_o |-> busy_o; endproperty
    a_req: assert property (p_req) else $error("stray fetch");
    property p_rise; $rose(mem_req_o) |-> $rose(busy_o); endproperty
    a_rise: assert property (p_rise) else $error("late fetch");
    property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
    a_hold: assert property (p_hold) else $error("fetch lost");
    property p_drop; ce_i && mem_req_o && mem_ack_i |=> !mem_req_o; endproperty
    a_drop: assert property (p_drop) else $error("fetch stuck");
    property p_tail; $fell(mem_req_o) |-> busy_o; endproperty
    a_tail: assert property (p_tail) else $error("op ended at ack");
    property p_rv; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o; endproperty
    a_rv: assert property (p_rv) else $error("read dropped");
    property p_ar; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
    a_ar: assert property (p_ar) else $error("read overlap");
endmodule
bind bcd_logic_rotate_alu bcd_logic_rotate_alu_sva sva_u (.clk_i, .reset_i, .ce_i, .busy_o,
    .mem_req_o, .mem_ack_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_arready_o, .mem_addr_o);

// ===== mem_model.sv
// memory operand responder that answers after a chosen lag
`timescale 1ns/1ps
module mem_model (
    input  wire logic        clk_i, req_i,
    input  wire logic [2:0]  lag_i,
    input  wire logic [15:0] addr_i,
    output logic             ack_o = 1'b0,
    output logic [7:0]       data_o = 8'h00
);
    logic [2:0] n = 3'h0; // idle cycles spent on this request, as wide as the lag
    wire logic go = req_i && !ack_o && n == lag_i;
    // one-cycle ack; data is scrambled outside it so stale bytes never pass
    always @(posedge clk_i) begin
        ack_o <= go;
        n <= (req_i && !ack_o && !go) ? n + 3'h1 : 3'h0;
        data_o <= go ? addr_i[15:8] ^ addr_i[7:0] ^ 8'h5a : ~data_o;
    end
endmodule
